/* File: rtl/lhi_host_port.sv */
// LCD driver host access port, parallel and serial
// Function
// - Bytes move over an eight-bit two-way bus or a serial data input line.
// - The interface select strap picks the parallel bus high and the serial link low, held static.
// - In serial mode bus bit 7 is data, bit 6 is clock, bits 5 to 0 float, unused pins tied.
// - The bus style strap high selects enable plus read/write, low selects separate strobes.
// - In enable style the read pin is the enable and the write pin the direction select.
// - Data/command high reads or writes display data, low reads status or writes a command.
// - The port works only while the low chip select is low and the high chip select is high.
// - Deselected, the bus floats and data/command and strobes are ignored.
// - Serial data and clock are taken only while the chip is selected.
// - Serial data is sampled on each rising serial clock, most significant bit first.
// - The eighth rising serial clock hands a whole byte to the internal path.
// - The data/command level marks a serial byte as display data or command.
// - Data/command is sampled at every eighth rising serial clock since selection.
// - Deselection clears the shift register and bit counter, dropping a partial byte.
// - The serial mode is write only and the host makes no reads there.
// - A status read shows busy on bus bit 7, and while busy only status reads are accepted.
`timescale 1ns/1ns
`default_nettype none
`include "lhi_regs.svh"
module lhi_host_port import lhi_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clock_enable,
   input wire logic interface_select,
   input wire logic bus_style_select,
   input wire logic chip_select_low_active,
   input wire logic chip_select_high_active,
   input wire logic data_command_select,
   input wire logic rd_enable_strobe,
   input wire logic wr_read_write_select,
   input wire logic [7:0] host_data_bus_in,
   output logic [7:0] host_data_bus_out,
   output logic [7:0] host_data_bus_oe,
   input wire logic busy,
   input wire logic [6:0] status_low,
   input wire logic [7:0] read_data,
   output logic write_valid,
   output lhi_byte_s write_byte,
   output logic read_req,
   output logic read_is_data
);
   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   lhi_pins_s pins_raw;
   lhi_pins_s pins;
   logic [1:0] straps;
   assign pins_raw = '{chip_select_low_active, chip_select_high_active, data_command_select,
      rd_enable_strobe, wr_read_write_select, host_data_bus_in};
   lhi_sync #(.W($bits(lhi_pins_s))) u_pin_sync
   (
      .clock(clock),
      .reset_n(reset_n),
      .clock_enable(clock_enable),
      .async_in(pins_raw),
      .sync_out(pins)
   );
   lhi_sync #(.W(2)) u_strap_sync
   (
      .clock(clock),
      .reset_n(reset_n),
      .clock_enable(clock_enable),
      .async_in({interface_select, bus_style_select}),
      .sync_out(straps)
   );
   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   logic parallel_mode;
   logic enable_style;
   logic selected;
   logic strobe_act;
   logic is_read;
   logic ser_clk;
   logic ser_dat;
   assign parallel_mode = straps[1];
   assign enable_style = straps[0];
   assign selected = !pins.chip_select_low_active && pins.chip_select_high_active;
   assign strobe_act = enable_style ? pins.rd : (!pins.rd || !pins.wr);
   assign is_read = enable_style ? pins.wr : !pins.rd;
   assign ser_dat = pins.bus[`LHI_SER_DATA_BIT];
   assign ser_clk = pins.bus[`LHI_SER_CLK_BIT];

   function automatic lhi_access_e access_kind(input logic rd_dir, input logic dc);
      access_kind = lhi_access_e'({rd_dir, dc});
   endfunction

   function automatic logic last_bit(input logic [3:0] count);
      last_bit = (count == `LHI_BITS_PER_BYTE - 4'h1);
   endfunction

   function automatic logic is_write(input lhi_access_e kind);
      is_write = (kind == LHI_CMD_WRITE) || (kind == LHI_DATA_WRITE);
   endfunction

   // ------------------------------------------------------------
   // Parallel strobe state machine
   // ------------------------------------------------------------
   lhi_strobe_e pstate_r;
   lhi_strobe_e pstate_nxt;
   logic par_go;
   logic par_end;
   assign par_go = parallel_mode && selected && strobe_act;
   always_comb
   begin
      pstate_nxt = pstate_r;
      case (pstate_r)
         LHI_IDLE: if (par_go) pstate_nxt = LHI_ACTIVE;
         LHI_ACTIVE: if (!par_go) pstate_nxt = LHI_DONE;
         LHI_DONE: pstate_nxt = LHI_REST;
         LHI_REST: pstate_nxt = LHI_IDLE;
         default: pstate_nxt = LHI_IDLE;
      endcase
   end
   assign par_end = (pstate_r == LHI_ACTIVE) && !par_go;
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         pstate_r <= LHI_IDLE;
      else if (clock_enable)
         pstate_r <= pstate_nxt;
   end

   // Access kind latched on every cycle of the strobe
   lhi_access_e kind_r;
   logic [7:0] wdata_r;
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         kind_r <= LHI_CMD_WRITE;
         wdata_r <= 8'h00;
      end
      else if (clock_enable && par_go)
      begin
         kind_r <= access_kind(is_read, pins.data_command_select);
         wdata_r <= pins.bus;
      end
   end

   // ------------------------------------------------------------
   // Serial shifter
   // ------------------------------------------------------------
   logic ser_clk_d_r;
   logic [7:0] shift_r;
   logic [3:0] count_r;
   logic ser_rise;
   logic ser_on;
   assign ser_on = !parallel_mode && selected;
   assign ser_rise = ser_on && ser_clk && !ser_clk_d_r;
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         ser_clk_d_r <= 1'b0;
      else if (clock_enable)
         ser_clk_d_r <= ser_clk;
   end
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         shift_r <= 8'h00;
      else if (clock_enable)
      begin
         if (!ser_on)
            shift_r <= 8'h00;
         else if (ser_rise)
            shift_r <= {shift_r[6:0], ser_dat};
      end
   end
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
         count_r <= 4'h0;
      else if (clock_enable)
      begin
         if (!ser_on)
            count_r <= 4'h0;
         else if (ser_rise)
            count_r <= last_bit(count_r) ? 4'h0 : count_r + 4'h1;
      end
   end

   // ------------------------------------------------------------
   // Byte outputs
   // ------------------------------------------------------------
   logic ser_last;
   assign ser_last = ser_rise && last_bit(count_r);
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         write_valid <= 1'b0;
         write_byte <= '0;
      end
      else if (clock_enable)
      begin
         write_valid <= 1'b0;
         if (ser_last)
         begin
            if (!busy)
            begin
               write_valid <= 1'b1;
               write_byte <= '{pins.data_command_select, {shift_r[6:0], ser_dat}};
            end
         end
         else if (par_end && !busy && is_write(kind_r))
         begin
            write_valid <= 1'b1;
            write_byte <= '{kind_r == LHI_DATA_WRITE, wdata_r};
         end
      end
   end

   // ------------------------------------------------------------
   // Read request outputs
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         read_req <= 1'b0;
         read_is_data <= 1'b0;
      end
      else if (clock_enable)
      begin
         read_req <= 1'b0;
         if (par_end && kind_r == LHI_STATUS_READ)
         begin
            read_req <= 1'b1;
            read_is_data <= 1'b0;
         end
         else if (par_end && !busy && kind_r == LHI_DATA_READ)
         begin
            read_req <= 1'b1;
            read_is_data <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Read data drive
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         host_data_bus_out <= `LHI_READ_DATA_RST;
         host_data_bus_oe <= 8'h00;
      end
      else if (clock_enable)
      begin
         if (par_go && is_read)
         begin
            host_data_bus_oe <= 8'hFF;
            if (!pins.data_command_select)
               host_data_bus_out <= {busy, status_low};
            else
               host_data_bus_out <= read_data;
         end
         else
         begin
            host_data_bus_oe <= 8'h00;
         end
      end
   end
endmodule
`default_nettype wire

/* File: rtl/lhi_regs.svh */
// Constants of the LCD host port
`ifndef LHI_REGS_SVH
`define LHI_REGS_SVH
`define LHI_DATA_W 8
`define LHI_BITS_PER_BYTE 4'h8
`define LHI_SER_DATA_BIT 7
`define LHI_SER_CLK_BIT 6
`define LHI_BUSY_BIT 7
`define LHI_STATUS_LOW_RST 7'h00
`define LHI_READ_DATA_RST 8'h00
`endif

/* File: rtl/lhi_pkg.sv */
// Types of the LCD host port
`default_nettype none
package lhi_pkg;
   typedef enum logic [1:0] {LHI_CMD_WRITE = 2'b00, LHI_DATA_WRITE = 2'b01, LHI_STATUS_READ = 2'b10,
      LHI_DATA_READ = 2'b11} lhi_access_e;
   typedef enum logic [1:0] {LHI_IDLE = 2'b00, LHI_ACTIVE = 2'b01, LHI_DONE = 2'b11,
      LHI_REST = 2'b10} lhi_strobe_e;
   typedef struct packed
   {
      logic is_data;
      logic [7:0] value;
   } lhi_byte_s;
   typedef struct packed
   {
      logic chip_select_low_active;
      logic chip_select_high_active;
      logic data_command_select;
      logic rd;
      logic wr;
      logic [7:0] bus;
   } lhi_pins_s;
endpackage
`default_nettype wire

/* File: rtl/lhi_sync.sv */
// Two-stage synchroniser for a group of pins
`timescale 1ns/1ns
`default_nettype none
module lhi_sync #(parameter int W = 1)
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic clock_enable,
   input wire logic [W-1:0] async_in,
   output logic [W-1:0] sync_out
);
   logic [W-1:0] meta_r;
   always_ff @(posedge clock or negedge reset_n)
   begin
      if (!reset_n)
      begin
         meta_r <= '0;
         sync_out <= '0;
      end
      else if (clock_enable)
      begin
         meta_r <= async_in;
         sync_out <= meta_r;
      end
   end
endmodule
`default_nettype wire

/* File: dv/lhi_host_port_asserts.sv */
// Checker of the host port pins
`timescale 1ns/1ns
`default_nettype none
module lhi_host_port_asserts import lhi_pkg::*;
(
   input wire logic clock,
   input wire logic reset_n,
   input wire logic interface_select,
   input wire logic chip_select_low_active,
   input wire logic chip_select_high_active,
   input wire logic busy,
   input wire logic [7:0] host_data_bus_oe,
   input wire logic write_valid,
   input wire lhi_byte_s write_byte,
   input wire logic read_req
);
   wire sel = !chip_select_low_active && chip_select_high_active;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   property p_oe_desel; !sel [*5] |=> host_data_bus_oe == 8'h00; endproperty
   a_oe_desel: assert property (p_oe_desel) else $error("bus driven while deselected");
   property p_ser_quiet; !interface_select [*5] |=> host_data_bus_oe == 8'h00 && !read_req; endproperty
   a_ser_quiet: assert property (p_ser_quiet) else $error("read activity in serial mode");
   property p_oe_whole; host_data_bus_oe == 8'h00 || host_data_bus_oe == 8'hFF; endproperty
   a_oe_whole: assert property (p_oe_whole) else $error("partial bus drive");
   property p_wv_pulse; write_valid |=> !write_valid; endproperty
   a_wv_pulse: assert property (p_wv_pulse) else $error("write pulse too long");
   property p_rr_pulse; read_req |=> !read_req; endproperty
   a_rr_pulse: assert property (p_rr_pulse) else $error("read pulse too long");
   property p_desel_idle; !sel [*6] |=> !write_valid && !read_req; endproperty
   a_desel_idle: assert property (p_desel_idle) else $error("access while deselected");
   property p_byte_hold; !write_valid |-> $stable(write_byte); endproperty
   a_byte_hold: assert property (p_byte_hold) else $error("byte changed without pulse");
   property p_busy_drop; busy |=> !write_valid; endproperty
   a_busy_drop: assert property (p_busy_drop) else $error("write taken while busy");
endmodule
bind lhi_host_port lhi_host_port_asserts u_chk (.clock, .reset_n, .interface_select, .chip_select_low_active,
   .chip_select_high_active, .busy, .host_data_bus_oe, .write_valid, .write_byte, .read_req);
`default_nettype wire

/* File: dv/lhi_host_model.sv */
// Host processor model on the pin side
`timescale 1ns/1ns
`default_nettype none
module lhi_host_model import lhi_pkg::*;
(
   input wire logic clock,
   input wire logic [7:0] bus_wire,
   output var lhi_pins_s pins,
   output logic interface_select,
   output logic bus_style_select
);
   initial
   begin
      pins = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00};
      interface_select = 1'b1;
      bus_style_select = 1'b0;
   end
   task automatic sel(input logic cl, input logic ch);
      @(negedge clock);
      pins.chip_select_low_active = cl;
      pins.chip_select_high_active = ch;
      repeat (4) @(negedge clock);
   endtask
   task automatic mode(input logic ps, input logic style);
      @(negedge clock);
      interface_select = ps;
      bus_style_select = style;
      pins.rd = !style;
      pins.wr = 1'b1;
      pins.bus = 8'h00;
      repeat (6) @(negedge clock);
   endtask
   task automatic par(input logic dc, input logic rnw, input logic [7:0] d, output logic [7:0] q);
      @(negedge clock);
      pins.data_command_select = dc;
      pins.bus = rnw ? ~pins.bus : d;
      pins.rd = bus_style_select | !rnw;
      pins.wr = rnw;
      repeat (6) @(negedge clock);
      q = bus_wire;
      pins.rd = !bus_style_select;
      pins.wr = 1'b1;
      repeat (6) @(negedge clock);
   endtask
   task automatic ser(input logic dc, input int n, input logic [7:0] d);
      for (int i = 7; i > 7 - n; i--)
      begin
         @(negedge clock);
         pins.data_command_select = dc;
         pins.bus[7] = d[i];
         pins.bus[6] = 1'b0;
         repeat (8) @(negedge clock);
         pins.bus[6] = 1'b1;
         repeat (7) @(negedge clock);
      end
      @(negedge clock);
      pins.bus[6] = 1'b0;
      pins.bus[7] = ~pins.bus[7];
      repeat (8) @(negedge clock);
   endtask
endmodule
`default_nettype wire

/* File: dv/lhi_host_port_tb.sv */
// Self-checking bench of the host port
`timescale 1ns/1ns
`default_nettype none
module lhi_host_port_tb import lhi_pkg::*;;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic busy = 1'b0;
   logic [6:0] status_low = 7'h55;
   logic [7:0] read_data = 8'h96;
   logic [7:0] q;
   logic got_rid;
   lhi_byte_s got;
   int n_mismatch = 0, total_checks = 0, nwv = 0, nrr = 0;
   wire logic [7:0] bus_out, bus_oe, bus_wire;
   wire logic interface_select, bus_style_select, wv, rr, rid;
   wire lhi_byte_s wb;
   wire lhi_pins_s pins;
   assign bus_wire = (bus_oe & bus_out) | (~bus_oe & pins.bus);
   lhi_host_model HOST (.clock, .bus_wire, .pins, .interface_select, .bus_style_select);
   lhi_host_port DUT (.clock, .reset_n, .clock_enable(1'b1), .interface_select, .bus_style_select,
      .chip_select_low_active(pins.chip_select_low_active), .chip_select_high_active(pins.chip_select_high_active),
      .data_command_select(pins.data_command_select), .rd_enable_strobe(pins.rd), .wr_read_write_select(pins.wr),
      .host_data_bus_in(bus_wire), .host_data_bus_out(bus_out), .host_data_bus_oe(bus_oe), .busy, .status_low,
      .read_data, .write_valid(wv), .write_byte(wb), .read_req(rr), .read_is_data(rid));
   initial
      forever #5 clock = ~clock;
   always @(posedge clock)
   begin
      nwv += (wv === 1'b1);
      nrr += (rr === 1'b1);
      if (wv === 1'b1)
         got = wb;
      if (rr === 1'b1)
         got_rid = rid;
   end
   task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
      total_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge clock);
      n_mismatch++;
      final_report();
   end
   initial
   begin
      repeat (12) @(negedge clock);
      reset_n = 1'b1;
      HOST.sel(1'b0, 1'b1);
      for (int s = 0; s < 2; s++)
      begin
         HOST.mode(1'b1, s[0]);
         HOST.par(1'b0, 1'b0, 8'hA5, q);
         chk("cmd", 9'h0A5, got);
         HOST.par(1'b1, 1'b0, 8'h3C, q);
         chk("dwr", 9'h13C, got);
         HOST.par(1'b0, 1'b1, 8'h00, q);
         chk("sts", 9'h055, {got_rid, q});
         HOST.par(1'b1, 1'b1, 8'h00, q);
         chk("drd", 9'h196, {got_rid, q});
      end
      $display("test parallel done");
      HOST.sel(1'b1, 1'b1);
      HOST.par(1'b0, 1'b0, 8'h11, q);
      HOST.sel(1'b0, 1'b0);
      HOST.par(1'b1, 1'b1, 8'h00, q);
      chk("float", 9'h0EE, {1'b0, q});
      chk("desel", 9'h044, {1'b0, nwv[3:0], nrr[3:0]});
      $display("test deselect done");
      HOST.sel(1'b0, 1'b1);
      busy = 1'b1;
      HOST.par(1'b1, 1'b0, 8'h77, q);
      HOST.par(1'b0, 1'b1, 8'h00, q);
      chk("busy", 9'h0D5, {1'b0, q});
      busy = 1'b0;
      chk("drop", 9'h045, {1'b0, nwv[3:0], nrr[3:0]});
      $display("test busy done");
      HOST.mode(1'b0, 1'b0);
      HOST.ser(1'b1, 8, 8'hC3);
      chk("ser_d", 9'h1C3, got);
      HOST.ser(1'b0, 8, 8'h5A);
      chk("ser_c", 9'h05A, got);
      busy = 1'b1;
      HOST.ser(1'b1, 8, 8'hE7);
      busy = 1'b0;
      chk("ser_busy", 9'h05A, wb);
      chk("ser_drop", 9'h065, {1'b0, nwv[3:0], nrr[3:0]});
      HOST.ser(1'b1, 3, 8'hFF);
      HOST.sel(1'b1, 1'b1);
      HOST.sel(1'b0, 1'b1);
      HOST.ser(1'b0, 8, 8'h81);
      chk("partial", 9'h081, got);
      HOST.sel(1'b1, 1'b0);
      HOST.ser(1'b1, 8, 8'h42);
      chk("ser_desel", 9'h075, {1'b0, nwv[3:0], nrr[3:0]});
      $display("test serial done");
      final_report();
   end
endmodule
`default_nettype wire
